/* verilog/adc_io_pkg.sv */
// Behaviour
// - After reset the enable bit is low; every write except to offset 0 is dropped, but reads still work.
// - Offset 0 bit 0 writes enable or disable I/O; register reads back.
// - Offset 0xD0 reads result bits 7 to 0.
// - Offset 0xD4 reads result bits 11 to 8 low, busy status in bit 4.
// - Status reads 1 while converting and 0 once finished.
// - Result is 12 bits: high nibble joined above the low byte.
// - Write to 0xE0 selects channel 0 to 31 from five low bits.
// - Write to 0xE4 sets gain code from three low bits, codes 0 to 4; codes 5 to 7 are also stored as written.
// - Any write to 0xF0 while enabled starts one conversion, before data is read.
// - Result offsets are read-only; channel, gain, trigger offsets write-only.
package adc_io_pkg;
	localparam logic [7:0] OFS_IO_ENABLE_CONTROL = 8'h00;
	localparam logic [7:0] OFS_RESULT_LOW = 8'hD0;
	localparam logic [7:0] OFS_RESULT_HIGH_STATUS = 8'hD4;
	localparam logic [7:0] OFS_CHANNEL_SELECT = 8'hE0;
	localparam logic [7:0] OFS_GAIN_CODE = 8'hE4;
	localparam logic [7:0] OFS_TRIGGER = 8'hF0;
	localparam int ENABLE_BIT = 0;
	localparam int STATUS_BIT = 4;
	localparam int CHANNEL_W = 5;
	localparam int GAIN_W = 3;
	localparam int RESULT_W = 12;
	localparam logic RST_ENABLE = 1'b0;
	localparam logic [4:0] RST_CHANNEL = 5'h00;
	localparam logic [2:0] RST_GAIN = 3'h0;
	localparam logic [11:0] RST_RESULT = 12'h000;
	localparam logic [2:0] GAIN_CODE_MAX = 3'h4;
endpackage

/* verilog/adc_conv_sync.sv */
`timescale 1ns/10ps
`default_nettype none
// Brings the converter's done level and data into the core clock domain.
// Data passes two stages every cycle beside done; the register logic only takes it once done is seen high.
module adc_conv_sync (
	// Clock and reset
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// Converter side
	input wire logic i_conv_done,
	input wire logic [11:0] i_conv_data,
	// Core side
	output logic o_done_sync,
	output logic [11:0] o_data_sync
);
	logic done_meta_r;
	logic [11:0] data_meta_r;

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			done_meta_r <= 1'b0;
			o_done_sync <= 1'b0;
			data_meta_r <= adc_io_pkg::RST_RESULT;
			o_data_sync <= adc_io_pkg::RST_RESULT;
		end else if (i_ce) begin
			done_meta_r <= i_conv_done;
			o_done_sync <= done_meta_r;
			data_meta_r <= i_conv_data;
			o_data_sync <= data_meta_r;
		end
	end
endmodule
`default_nettype wire

/* verilog/adc_io_regs.sv */
`timescale 1ns/10ps
`default_nettype none
// Register logic of a software-triggered 12-bit converter card, reached by
// byte I/O reads and writes at offsets from the card's base.
module adc_io_regs (
	// Clock, reset, enable
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// Host byte I/O port
	input wire logic [7:0] i_io_addr,
	input wire logic i_io_wr,
	input wire logic i_io_rd,
	input wire logic [7:0] i_io_wdata,
	output logic [7:0] o_io_rdata,
	// Converter front end
	input wire logic i_conv_done,
	input wire logic [11:0] i_conv_data,
	output logic o_conv_start,
	output logic [4:0] o_channel_select,
	output logic [2:0] o_programmable_amplifier_gain,
	output logic o_io_enabled_n_high
);
	typedef enum logic [1:0] {
		CONV_IDLE,
		CONV_WAIT_BUSY,
		CONV_WAIT_DONE
	} conv_state_e;

	conv_state_e conv_state_r;
	logic enable_r;
	logic [4:0] channel_r;
	logic [2:0] gain_r;
	logic [11:0] result_r;
	logic busy_r;
	logic done_sync;
	logic [11:0] data_sync;
	logic wr_ok;
	logic trig_wr;
	logic wr_enable_ctl;
	logic wr_channel;
	logic wr_gain;
	logic conv_finish;
	conv_state_e conv_state_nxt;
	logic [7:0] rdata_nxt;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		hit = (a == ofs);
	endfunction

	adc_conv_sync u_sync (
		.i_core_clk(i_core_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.i_conv_done(i_conv_done),
		.i_conv_data(i_conv_data),
		.o_done_sync(done_sync),
		.o_data_sync(data_sync)
	);

	// Write decode. Only the enable register answers while the enable bit is
	// low; every other write is dropped, so a card left disabled can neither
	// start a conversion nor move the channel or gain outputs.
	assign wr_ok = i_io_wr && enable_r;
	assign wr_enable_ctl = i_io_wr && hit(i_io_addr, adc_io_pkg::OFS_IO_ENABLE_CONTROL);
	assign wr_channel = wr_ok && hit(i_io_addr, adc_io_pkg::OFS_CHANNEL_SELECT);
	assign wr_gain = wr_ok && hit(i_io_addr, adc_io_pkg::OFS_GAIN_CODE);
	assign trig_wr = wr_ok && hit(i_io_addr, adc_io_pkg::OFS_TRIGGER);
	// Writes to the result offsets or to unmapped offsets match no strobe and are lost.

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			enable_r <= adc_io_pkg::RST_ENABLE;
		end else if (i_ce && wr_enable_ctl) begin
			enable_r <= i_io_wdata[adc_io_pkg::ENABLE_BIT];
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			channel_r <= adc_io_pkg::RST_CHANNEL;
		end else if (i_ce && wr_channel) begin
			channel_r <= i_io_wdata[adc_io_pkg::CHANNEL_W-1:0];
		end
	end

	// Codes above the largest gain are kept as written; the amplifier decides.
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			gain_r <= adc_io_pkg::RST_GAIN;
		end else if (i_ce && wr_gain) begin
			gain_r <= i_io_wdata[adc_io_pkg::GAIN_W-1:0];
		end
	end

	// Conversion sequence. A trigger sends one start pulse and then waits for
	// the converter to drop its done level before a high done counts again, so
	// a stale done level from the previous conversion cannot end this one.
	// The done level and the data both pass the two-stage synchroniser; the
	// data is only taken once done has been seen high, when the converter
	// holds it still. The cost is a few cycles of latency per conversion,
	// which is small against the converter's own conversion time.
	always_comb begin
		conv_state_nxt = conv_state_r;
		if (trig_wr) begin
			conv_state_nxt = CONV_WAIT_BUSY;
		end else begin
			case (conv_state_r)
				CONV_IDLE: begin
					conv_state_nxt = CONV_IDLE;
				end
				CONV_WAIT_BUSY: begin
					if (!done_sync) begin
						conv_state_nxt = CONV_WAIT_DONE;
					end
				end
				CONV_WAIT_DONE: begin
					if (done_sync) begin
						conv_state_nxt = CONV_IDLE;
					end
				end
				default: begin
					conv_state_nxt = CONV_IDLE;
				end
			endcase
		end
	end

	// A retrigger in the cycle a conversion finishes wins; that result is dropped.
	assign conv_finish = !trig_wr && (conv_state_r == CONV_WAIT_DONE) && done_sync;

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			conv_state_r <= CONV_IDLE;
		end else if (i_ce) begin
			conv_state_r <= conv_state_nxt;
		end
	end

	// Set wins over clear, so a retrigger keeps the card busy.
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			busy_r <= 1'b0;
		end else if (i_ce) begin
			if (trig_wr) begin
				busy_r <= 1'b1;
			end else if (conv_finish) begin
				busy_r <= 1'b0;
			end
		end
	end

	// The result only moves when a conversion completes, so the host can still
	// read the previous result while a new conversion is under way.
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			result_r <= adc_io_pkg::RST_RESULT;
		end else if (i_ce && conv_finish) begin
			result_r <= data_sync;
		end
	end

	// One-cycle start pulse, raised only for a trigger that passed the enable gate.
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_conv_start <= 1'b0;
		end else if (i_ce) begin
			o_conv_start <= trig_wr;
		end
	end

	// Reads are not gated by the enable bit, so the host can always check it.
	// Write-only and unmapped offsets read as zero.
	always_comb begin
		rdata_nxt = 8'h00;
		if (i_io_rd) begin
			case (i_io_addr)
				adc_io_pkg::OFS_IO_ENABLE_CONTROL: begin
					rdata_nxt = {7'h00, enable_r};
				end
				adc_io_pkg::OFS_RESULT_LOW: begin
					rdata_nxt = result_r[7:0];
				end
				adc_io_pkg::OFS_RESULT_HIGH_STATUS: begin
					rdata_nxt = {3'h0, busy_r, result_r[11:8]};
				end
				default: begin
					rdata_nxt = 8'h00;
				end
			endcase
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_io_rdata <= 8'h00;
		end else if (i_ce) begin
			o_io_rdata <= rdata_nxt;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_channel_select <= adc_io_pkg::RST_CHANNEL;
			o_programmable_amplifier_gain <= adc_io_pkg::RST_GAIN;
			o_io_enabled_n_high <= adc_io_pkg::RST_ENABLE;
		end else if (i_ce) begin
			o_channel_select <= channel_r;
			o_programmable_amplifier_gain <= gain_r;
			o_io_enabled_n_high <= enable_r;
		end
	end
endmodule
`default_nettype wire

/* test/adc_io_regs_checker.sv */
`timescale 1ns/10ps
`default_nettype none
module adc_io_regs_checker (
	input wire logic i_core_clk,
	input wire logic i_rst,
	input wire logic [7:0] i_io_addr,
	input wire logic i_io_wr,
	input wire logic i_io_rd,
	input wire logic [7:0] i_io_wdata,
	input wire logic [7:0] o_io_rdata,
	input wire logic o_conv_start,
	input wire logic [4:0] o_channel_select,
	input wire logic [2:0] o_programmable_amplifier_gain,
	input wire logic o_io_enabled_n_high
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_rst);
	wire logic [4:0] wd = i_io_wdata[4:0];
	wire logic [2:0] wg = i_io_wdata[2:0];
	sequence trig_s; i_io_wr && i_io_addr == 8'hF0; endsequence
	sequence hi_rd_s; i_io_rd && i_io_addr == 8'hD4; endsequence
	start_pulse_a: assert property (trig_s ##0 o_io_enabled_n_high |=> o_conv_start ##1 !o_conv_start)
		else $error("bad start pulse");
	off_ignore_a: assert property (trig_s ##1 !o_io_enabled_n_high |-> !o_conv_start)
		else $error("start while off");
	busy_set_a: assert property (trig_s ##0 o_io_enabled_n_high ##2 hi_rd_s |=> o_io_rdata[4])
		else $error("busy not set");
	idle_zero_a: assert property (!i_io_rd |=> o_io_rdata == 8'h00) else $error("rdata not idle");
	wo_read_a: assert property (i_io_rd && i_io_addr inside {8'hE0, 8'hE4, 8'hF0} |=> o_io_rdata == 8'h00)
		else $error("write-only read");
	en_read_a: assert property (i_io_rd && i_io_addr == 8'h00 |=> o_io_rdata == {7'h00, o_io_enabled_n_high})
		else $error("enable readback");
	chan_set_a: assert property (i_io_wr && i_io_addr == 8'hE0 && o_io_enabled_n_high |-> ##2 o_channel_select == $past(wd, 2))
		else $error("channel wrong");
	gain_set_a: assert property (i_io_wr && i_io_addr == 8'hE4 && o_io_enabled_n_high |-> ##2 o_programmable_amplifier_gain == $past(wg, 2))
		else $error("gain wrong");
endmodule
bind adc_io_regs adc_io_regs_checker u_chk (.i_core_clk, .i_rst, .i_io_addr, .i_io_wr, .i_io_rd, .i_io_wdata,
	.o_io_rdata, .o_conv_start, .o_channel_select, .o_programmable_amplifier_gain, .o_io_enabled_n_high);
`default_nettype wire

/* test/adc_conv_model.sv */
`timescale 1ns/10ps
`default_nettype none
// Converter stand-in; data toggles while busy so a stale capture cannot pass.
module adc_conv_model #(parameter int DLY = 6) (
	input wire logic i_core_clk,
	input wire logic i_start,
	input wire logic [4:0] i_chan,
	input wire logic [2:0] i_gain,
	output logic o_done,
	output logic [11:0] o_data
);
	initial begin
		o_done = 1'b1;
		o_data = 12'h000;
	end
	always @(posedge i_core_clk) begin
		if (i_start) begin
			o_done <= 1'b0;
			repeat (DLY) begin
				@(posedge i_core_clk);
				o_data <= ~o_data;
			end
			o_data <= {i_chan, i_gain, 4'h5};
			o_done <= 1'b1;
		end
	end
endmodule
`default_nettype wire

/* test/isolated_adc_io_register_control_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module isolated_adc_io_register_control_tb_top;
	logic i_core_clk = 1'b0, i_rst = 1'b1, i_io_wr = 1'b0, i_io_rd = 1'b0, done, start, en;
	logic [7:0] i_io_addr = 8'h00, i_io_wdata = 8'h00, rdata, got;
	logic [11:0] data;
	logic [4:0] chan;
	logic [2:0] gain;
	int err_total = 0, compares = 0, cyc = 0;
	always #5 i_core_clk = ~i_core_clk;
	adc_io_regs DUT (.i_core_clk, .i_rst, .i_ce(1'b1), .i_io_addr, .i_io_wr, .i_io_rd, .i_io_wdata,
		.o_io_rdata(rdata), .i_conv_done(done), .i_conv_data(data), .o_conv_start(start),
		.o_channel_select(chan), .o_programmable_amplifier_gain(gain), .o_io_enabled_n_high(en));
	adc_conv_model u_conv (.i_core_clk, .i_start(start), .i_chan(chan), .i_gain(gain), .o_done(done), .o_data(data));
	task automatic chk(input logic [7:0] g, e);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic io(input logic w, input logic [7:0] a, d);
		@(posedge i_core_clk);
		i_io_wr <= w;
		i_io_rd <= !w;
		i_io_addr <= a;
		i_io_wdata <= d;
		@(posedge i_core_clk);
		i_io_wr <= 1'b0;
		i_io_rd <= 1'b0;
		#1 got = rdata;
	endtask
	task automatic t_cfg;
		io(1, 8'hE0, 8'h07);
		io(1, 8'hF0, 8'h00);
		io(0, 8'h00, 8'h00);
		chk({3'h0, chan}, 8'h00);
		io(1, 8'h00, 8'hFF);
		io(0, 8'h00, 8'h00);
		chk(got, 8'h01);
		chk({7'h00, en}, 8'h01);
		for (int g = 0; g < 5; g++) begin
			io(1, 8'hE4, 8'hF8 | 8'(g));
			@(posedge i_core_clk);
			#1 chk({5'h00, gain}, 8'(g));
		end
		io(1, 8'hE0, 8'hFF);
		@(posedge i_core_clk);
		#1 chk({3'h0, chan}, 8'h1F);
	endtask
	task automatic t_conv;
		int n;
		io(1, 8'hF0, 8'hA5);
		io(0, 8'hD4, 8'h00);
		chk(got & 8'h10, 8'h10);
		n = 0;
		while (got[4] !== 1'b0 && n < 50) begin
			io(0, 8'hD4, 8'h00);
			n++;
		end
		chk(got & 8'h1F, 8'h0F);
		io(0, 8'hD0, 8'h00);
		chk(got, 8'hC5);
		io(1, 8'hD0, 8'h00);
		io(0, 8'hE0, 8'h00);
		chk(got, 8'h00);
		io(0, 8'hD0, 8'h00);
		chk(got, 8'hC5);
		io(1, 8'hE0, 8'h03);
		io(1, 8'hE4, 8'h01);
		io(1, 8'hF0, 8'h00);
		io(0, 8'hD0, 8'h00);
		chk(got, 8'hC5);
		n = 0;
		got = 8'h10;
		while (got[4] !== 1'b0 && n < 50) begin
			io(0, 8'hD4, 8'h00);
			n++;
		end
		chk(got & 8'h1F, 8'h01);
		io(0, 8'hD0, 8'h00);
		chk(got, 8'h95);
		io(1, 8'h00, 8'h00);
		io(0, 8'h00, 8'h00);
		chk(got, 8'h00);
	endtask
	task automatic report_and_stop;
		$display("errors %0d compares %0d", err_total, compares);
		if (err_total == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge i_core_clk);
		i_rst <= 1'b0;
		t_cfg();
		t_conv();
		report_and_stop();
	end
	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			err_total++;
			report_and_stop();
		end
	end
endmodule
`default_nettype wire
